// ===== verification/dobank_lines_model.sv
module dobank_lines_model
  import dobank_pkg::*;
(
  // lines from the bank
  input wire logic [31:0] out_lines,
  input wire logic [31:0] out_lines_oe,
  // level seen by the load; undriven lines sit on a pull-down
  output logic [31:0] line_level
);
  assign line_level = out_lines & out_lines_oe;
endmodule : dobank_lines_model

// ===== verification/tb_top.sv
module tb_top import dobank_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset = 1, dir_wr = 0, wr_req = 0, rd_req = 0;
  logic [3:0] dir_mask = 0, dir_value = 0, dir_state;
  logic [1:0] rd_port = 0;
  dobank_write_t wr_cmd = '0;
  dobank_status_t status;
  logic [7:0] rd_data, last_rd = 0, v;
  logic [31:0] out_lines, out_lines_oe, line_level, x;
  logic [9:0] exp_q[$];
  logic [7:0] rd_q[$];
  int n_mismatch = 0, comparisons = 0;
  always #12.5 core_clk = ~core_clk;
  dobank_top DUT(.core_clk(core_clk), .reset(reset), .dir_wr(dir_wr), .dir_mask(dir_mask),
    .dir_value(dir_value), .wr_req(wr_req), .wr_cmd(wr_cmd), .rd_req(rd_req),
    .rd_port(rd_port), .status(status), .rd_data(rd_data), .dir_state(dir_state),
    .out_lines(out_lines), .out_lines_oe(out_lines_oe));
  dobank_lines_model load(.out_lines(out_lines), .out_lines_oe(out_lines_oe),
    .line_level(line_level));
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one request per call; the idle cycle between calls keeps strobes clean
  task automatic req(input logic rd, input dobank_width_t w, input logic [1:0] p,
      input logic [31:0] d, input logic ok, input logic [7:0] rdv);
    @(negedge core_clk);
    wr_req = !rd;
    rd_req = rd;
    wr_cmd = '{w, p, d};
    rd_port = p;
    exp_q.push_back({ok, ok ? 9'h000 : DOBANK_ERR_CONFLICT});
    if (ok && rd) last_rd = rdv;
    rd_q.push_back(last_rd);
    @(negedge core_clk);
    wr_req = 0;
    rd_req = 0;
  endtask : req
  task automatic set_dir(input logic [3:0] m, input logic [3:0] val);
    @(negedge core_clk);
    dir_wr = 1;
    dir_mask = m;
    dir_value = val;
    @(negedge core_clk);
    dir_wr = 0;
    repeat (2) @(negedge core_clk);
  endtask : set_dir
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  // status stands one cycle, so the falling edge sees each answer once
  always @(negedge core_clk) if (status.valid === 1'b1) begin
    if (exp_q.size() == 0) check(32'h1, 32'h0);
    else begin
      check(status[9:0], exp_q.pop_front());
      check(rd_data, rd_q.pop_front());
    end
  end
  initial begin
    #100us;
    n_mismatch++;
    close_out();
  end
  initial begin
    void'($urandom(32'h113D));
    repeat (5) @(negedge core_clk);
    reset = 0;
    @(negedge core_clk);
    check({dir_state, out_lines_oe}, 36'h0);
    req(0, DOBANK_W_BYTE, 2'h1, 32'hA5, 0, 0);
    $display("test reset and refusal done");
    set_dir(4'hF, 4'hF);
    x = $urandom;
    req(0, DOBANK_W_DWORD, DOBANK_PORT_ONE, x, 1, 0);
    repeat (2) @(negedge core_clk);
    check(line_level, x);
    for (int i = 0; i < 4; i++) req(1, DOBANK_W_NONE, 2'(i), 0, 1, x[i*8+:8]);
    $display("test double-word done");
    for (int i = 0; i < 4; i++) begin
      v = i[0] ? 8'hFF : 8'($urandom);
      req(0, DOBANK_W_BYTE, 2'(i), {24'($urandom), v}, 1, 0);
      x[i*8+:8] = v;
      repeat (2) @(negedge core_clk);
      check(line_level, x);
    end
    $display("test bytes done");
    v = 8'($urandom);
    req(0, DOBANK_W_WORD, DOBANK_PORT_THREE, {16'h0, v, ~v}, 1, 0);
    x[31:16] = {v, ~v};
    req(0, DOBANK_W_WORD, 2'h1, 32'h0, 0, 0);
    set_dir(4'h4, 4'h0);
    check(dir_state, 4'hB);
    req(1, DOBANK_W_NONE, DOBANK_PORT_THREE, 0, 0, 0);
    req(0, DOBANK_W_DWORD, DOBANK_PORT_ONE, 32'h0, 0, 0);
    repeat (3) @(negedge core_clk);
    check(line_level, x & 32'hFF00FFFF);
    check(exp_q.size(), 0);
    $display("test words and inputs done");
    @(negedge core_clk);
    reset = 1;
    repeat (2) @(negedge core_clk);
    reset = 0;
    last_rd = 8'h00;
    @(negedge core_clk);
    check({dir_state, out_lines_oe}, 36'h0);
    check(line_level, 32'h0);
    req(0, DOBANK_W_BYTE, DOBANK_PORT_ONE, 32'h5A, 0, 0);
    req(1, DOBANK_W_NONE, DOBANK_PORT_ONE, 0, 0, 0);
    repeat (2) @(negedge core_clk);
    check(exp_q.size(), 0);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : tb_top

// ===== verilog/dobank_pkg.sv
package dobank_pkg;
  localparam int DOBANK_PORTS = 4;
  localparam int DOBANK_PORT_W = 8;
  // write widths
  typedef enum logic [1:0] {
    DOBANK_W_BYTE = 2'b00,
    DOBANK_W_WORD = 2'b01,
    DOBANK_W_DWORD = 2'b10,
    DOBANK_W_NONE = 2'b11
  } dobank_width_t;
  // port index positions
  localparam logic [1:0] DOBANK_PORT_ONE = 2'h0;
  localparam logic [1:0] DOBANK_PORT_THREE = 2'h2;
  localparam logic [7:0] DOBANK_PATTERN_RST = 8'h00;
  localparam logic [3:0] DOBANK_DIR_RST = 4'h0;
  localparam logic [8:0] DOBANK_ERR_CONFLICT = 9'h123; // two's complement of 221 in 9 bits
  typedef struct packed {
    dobank_width_t width;
    logic [1:0] port;
    logic [31:0] data;
  } dobank_write_t;
  typedef struct packed {
    logic valid;
    logic ok;
    logic [8:0] code;
  } dobank_status_t;
endpackage : dobank_pkg

// ===== verilog/dobank_regs.sv
module dobank_regs
  import dobank_pkg::*;
#(
  parameter int PORTS = DOBANK_PORTS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // per-port write strobes and data
  input wire logic [PORTS-1:0] wr_en,
  input wire logic [PORTS*8-1:0] wr_data,
  // stored pattern
  output logic [PORTS*8-1:0] pattern
);
  // each port owns one strobe bit and one byte of the data bus, so zero ports leaves nothing
  if (PORTS < 1) begin : g_bad_ports
    $error("dobank_regs needs at least one port");
  end

  generate
    for (genvar i = 0; i < PORTS; i++) begin : g_port
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          pattern[i*8 +: 8] <= DOBANK_PATTERN_RST;
        end else if (wr_en[i]) begin
          pattern[i*8 +: 8] <= wr_data[i*8 +: 8];
        end
      end
    end
  endgenerate
endmodule : dobank_regs

// ===== verilog/dobank_top.sv
// Functional notes
// - pattern write refused unless port is output
// - byte write changes only addressed port
// - byte, word and double-word widths supported
// - ports one/two carry bits 0..15
// - ports three/four carry bits 16..31
// - one drives line high, zero low
// - any byte 0 to 255 accepted
// - set pattern reads back unchanged
// - reset makes all ports inputs
// - input port access gives error -221
module dobank_top
  import dobank_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // direction control
  input wire logic dir_wr,
  input wire logic [3:0] dir_mask,
  input wire logic [3:0] dir_value,
  // pattern write
  input wire logic wr_req,
  input wire dobank_write_t wr_cmd,
  // pattern read
  input wire logic rd_req,
  input wire logic [1:0] rd_port,
  // results
  output dobank_status_t status,
  output logic [7:0] rd_data,
  output logic [3:0] dir_state,
  // external lines
  output logic [31:0] out_lines,
  output logic [31:0] out_lines_oe
);
  logic [3:0] dir;
  logic [3:0] span;
  logic legal;
  logic [3:0] wr_en;
  logic [31:0] wr_data;
  logic [31:0] pattern;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dir <= DOBANK_DIR_RST;
    end else if (dir_wr) begin
      dir <= (dir & ~dir_mask) | (dir_value & dir_mask);
    end
  end

  // ports touched by the request, and whether the start port is legal
  // wide writes must start on an aligned port: words at port one or three, double-words at port one
  always_comb begin
    span = 4'h0;
    legal = 1'b0;
    case (wr_cmd.width)
      DOBANK_W_BYTE: begin
        span = 4'h1 << wr_cmd.port;
        legal = 1'b1;
      end
      DOBANK_W_WORD: begin
        span = 4'h3 << wr_cmd.port;
        legal = (wr_cmd.port == DOBANK_PORT_ONE) || (wr_cmd.port == DOBANK_PORT_THREE);
      end
      DOBANK_W_DWORD: begin
        span = 4'hF;
        legal = (wr_cmd.port == DOBANK_PORT_ONE);
      end
      default: begin
        span = 4'h0;
        legal = 1'b0;
      end
    endcase
  end

  // whole request refused if any spanned port is an input: no partial update
  assign wr_en = (wr_req && legal && ((span & ~dir) == 4'h0)) ? span : 4'h0;

  // low data byte lands on the start port, higher bytes on the next ports
  always_comb begin
    wr_data = 32'h0000_0000;
    case (wr_cmd.port)
      2'h0: wr_data = wr_cmd.data;
      2'h1: wr_data = {wr_cmd.data[23:0], 8'h00};
      2'h2: wr_data = {wr_cmd.data[15:0], 16'h0000};
      default: wr_data = {wr_cmd.data[7:0], 24'h000000};
    endcase
  end

  dobank_regs #(
    .PORTS(DOBANK_PORTS)
  ) u_regs (
    .core_clk(core_clk),
    .reset(reset),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .pattern(pattern)
  );

  // status answers one cycle after a request
  // a read that meets a write is dropped; the host must ask again
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      status <= '0;
      rd_data <= 8'h00;
    end else begin
      status.valid <= wr_req || rd_req;
      status.ok <= 1'b0;
      status.code <= 9'h000;
      if (wr_req) begin
        status.ok <= (wr_en != 4'h0);
        status.code <= (wr_en != 4'h0) ? 9'h000 : DOBANK_ERR_CONFLICT;
      end else if (rd_req) begin
        status.ok <= dir[rd_port];
        status.code <= dir[rd_port] ? 9'h000 : DOBANK_ERR_CONFLICT;
      end
      if (rd_req && !wr_req && dir[rd_port]) begin
        rd_data <= pattern[rd_port*8 +: 8];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dir_state <= DOBANK_DIR_RST;
    end else begin
      dir_state <= dir;
    end
  end

  // registered so decode glitches never reach the pins
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_lines <= {DOBANK_PORTS{DOBANK_PATTERN_RST}};
    end else begin
      out_lines <= pattern;
    end
  end

  // an input port lets go of its lines but keeps its pattern
  generate
    for (genvar i = 0; i < DOBANK_PORTS; i++) begin : g_oe
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          out_lines_oe[i*8 +: 8] <= 8'h00;
        end else begin
          out_lines_oe[i*8 +: 8] <= {8{dir[i]}};
        end
      end
    end
  endgenerate

  // named steps shared by the answer checks
  sequence s_write_refused;
    wr_req && wr_en == 4'h0;
  endsequence
  sequence s_read_refused;
    rd_req && !wr_req && !dir[rd_port];
  endsequence
  sequence s_conflict_answer;
    status.valid && !status.ok && status.code == DOBANK_ERR_CONFLICT;
  endsequence
  sequence s_clean_answer;
    status.valid && status.ok && status.code == 9'h000;
  endsequence

  a_refuse_input: assert property (@(posedge core_clk) disable iff (reset)
    wr_req && (span & ~dir) != 4'h0 |=> $stable(pattern))
    else $error("pattern changed on input port");
  a_conflict_code: assert property (@(posedge core_clk) disable iff (reset)
    s_write_refused |=> s_conflict_answer)
    else $error("missing conflict code");
  a_byte_only: assert property (@(posedge core_clk) disable iff (reset)
    wr_req && wr_cmd.width == DOBANK_W_BYTE |=>
      ((pattern ^ $past(pattern)) & ~({24'h0, 8'hFF} << ($past(wr_cmd.port) * 8))) == 0)
    else $error("byte write touched other port");
  a_dword_map: assert property (@(posedge core_clk) disable iff (reset)
    wr_req && wr_cmd.width == DOBANK_W_DWORD && wr_en == 4'hF |=>
      pattern == $past(wr_cmd.data))
    else $error("double-word mapping wrong");
  a_lines_follow: assert property (@(posedge core_clk) disable iff (reset)
    ##1 out_lines == $past(pattern))
    else $error("lines not following pattern");
  a_read_back: assert property (@(posedge core_clk) disable iff (reset)
    rd_req && !wr_req && dir[rd_port] |=> rd_data == $past(pattern[rd_port*8 +: 8]))
    else $error("readback mismatch");
  a_reset_dir: assert property (@(posedge core_clk)
    $fell(reset) |-> dir == 4'h0)
    else $error("direction not cleared by reset");
  a_word_span: assert property (@(posedge core_clk) disable iff (reset)
    wr_req && wr_cmd.width == DOBANK_W_WORD && wr_en != 4'h0 |=>
      pattern[$past(wr_cmd.port)*8 +: 16] == $past(wr_cmd.data[15:0]))
    else $error("word write wrong");
  // answers, refusals, word write scope and reset lines
  a_write_clean: assert property (@(posedge core_clk) disable iff (reset)
    wr_req && wr_en != 4'h0 |=> s_clean_answer)
    else $error("accepted write without clean answer");
  a_read_clean: assert property (@(posedge core_clk) disable iff (reset)
    rd_req && !wr_req && dir[rd_port] |=> s_clean_answer)
    else $error("accepted read without clean answer");
  a_read_conflict: assert property (@(posedge core_clk) disable iff (reset)
    s_read_refused |=> s_conflict_answer)
    else $error("input port read without conflict code");
  a_read_hold: assert property (@(posedge core_clk) disable iff (reset)
    s_read_refused |=> $stable(rd_data))
    else $error("refused read changed read data");
  a_illegal_start: assert property (@(posedge core_clk) disable iff (reset)
    wr_req && !legal |=> $stable(pattern))
    else $error("misplaced wide write changed pattern");
  a_word_only: assert property (@(posedge core_clk) disable iff (reset)
    wr_req && wr_cmd.width == DOBANK_W_WORD && wr_en != 4'h0 |=>
      ((pattern ^ $past(pattern)) & ~(32'h0000_FFFF << ($past(wr_cmd.port) * 8))) == 0)
    else $error("word write touched other ports");
  a_answer_only: assert property (@(posedge core_clk) disable iff (reset)
    !wr_req && !rd_req |=> !status.valid)
    else $error("status answer without request");
  a_reset_lines: assert property (@(posedge core_clk)
    $fell(reset) |-> out_lines_oe == 32'h0000_0000 && dir_state == DOBANK_DIR_RST)
    else $error("lines still driven after reset");
endmodule : dobank_top
